//--- hdl/ssds_pkg.sv
// shared constants for the sensorless stall detect and stop block
package ssds_pkg;
    // register bus shape
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // register offsets
    localparam logic [3:0] OFS_CONFIG  = 4'h0; // stop enable, filter, threshold
    localparam logic [3:0] OFS_VLOW    = 4'h1; // lower velocity bound
    localparam logic [3:0] OFS_VHIGH   = 4'h2; // upper velocity bound
    localparam logic [3:0] OFS_WAIT    = 4'h3; // standstill wait time, microseconds
    localparam logic [3:0] OFS_EVENT   = 4'h4; // motion event register, read clears
    localparam logic [3:0] OFS_MASK    = 4'h5; // interrupt mask
    localparam logic [3:0] OFS_DRVSTAT = 4'h6; // driver state register
    // config field positions
    localparam int CFG_STOP_BIT = 0;
    localparam int CFG_FILT_BIT = 1;
    localparam int CFG_THR_LSB  = 8;
    localparam int THR_W        = 7;
    // event and driver state fields
    localparam int EV_STALL_BIT = 0;
    localparam int EV_LOAD_BIT  = 1;
    localparam int EV_W         = 2;
    localparam int DS_STALL_BIT = 16;
    localparam int DS_WAIT_BIT  = 17;
    // measurement shape
    localparam int LOAD_W   = 10;
    localparam int VEL_W    = 24;
    localparam int WAIT_W   = 16;
    localparam int THR_SHIFT = 4;  // threshold step in load counts (log2)
    localparam logic [9:0] LOAD_MAX = 10'h3FF;
    localparam int FILT_LEN = 4;
    // reset values
    localparam logic [23:0] VLOW_RST  = 24'h000000;
    localparam logic [23:0] VHIGH_RST = 24'hFFFFFF;
    localparam logic [15:0] WAIT_RST  = 16'h0000;
    // timing: one microsecond tick from the 100 MHz clock
    localparam int CLK_NS     = 10;
    localparam int TICK_NS    = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    // stop sequencer states
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_HALT = 2'b01,
        ST_WAIT = 2'b10
    } ssds_state_type;
endpackage

//--- hdl/ssds_stall_detect.sv
// stall detection with automatic stop, load filter and register port
//
// Function
// - load result updated every full step, or every fourth step with the filter on
// - optional filter averages four successive measurements
// - stall with stop enabled halts, velocity zero
// - stall stop shown in driver state flag
// - event read clears; restart after standstill wait
// - clearing stop enable releases the halt
// - load reading zero counts as stall
// - stall threshold is a signed setting
// - velocity window bounds valid stall detection
// - load result unsigned, 0 to 1023
// - threshold up to +63, zero neutral
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module ssds_stall_detect
    import ssds_pkg::*;
(
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    // register port
    input  wire logic [ssds_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [ssds_pkg::DATA_W-1:0] regWrData,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [ssds_pkg::DATA_W-1:0] regRdData,
    // measurement front end, same clock
    input  wire logic                      fullStepStrobe,
    input  wire logic [ssds_pkg::LOAD_W-1:0] rawLoad,
    // ramp generator
    input  wire logic signed [ssds_pkg::VEL_W-1:0] presentVelocity,
    output logic                           rampHalt,
    output logic                           forceVelocityZero,
    // interrupt
    output logic                           irq
);
    import ssds_pkg::*;

    // configuration registers
    logic                    stopEn_r, stopEn_nxt;      // stop_on_stall_enable
    logic                    filtEn_r, filtEn_nxt;      // load filter enable
    logic signed [THR_W-1:0] thr_r, thr_nxt;            // stall_threshold
    logic [VEL_W-1:0]        vLow_r, vLow_nxt;          // lower velocity bound
    logic [VEL_W-1:0]        vHigh_r, vHigh_nxt;        // upper velocity bound
    logic [WAIT_W-1:0]       waitTime_r, waitTime_nxt;  // standstill_wait_time
    logic [EV_W-1:0]         mask_r, mask_nxt;          // interrupt mask
    logic [EV_W-1:0]         event_r, event_nxt;        // sticky events
    logic [DATA_W-1:0]       rdData_r, rdData_nxt;      // read data, one cycle late
    // measurement path
    logic [LOAD_W-1:0]       load_r, load_nxt;          // load_measurement result
    logic                    loadUpd_r, loadUpd_nxt;    // result just updated
    logic [LOAD_W+1:0]       acc_r, acc_nxt;            // filter accumulator
    logic [1:0]              phase_r, phase_nxt;        // filter sample index
    // stop sequencer
    ssds_state_type          state_r, state_nxt;
    logic [WAIT_W-1:0]       waitCnt_r, waitCnt_nxt;    // elapsed wait ticks
    logic [6:0]              tickCnt_r, tickCnt_nxt;    // microsecond divider
    logic                    tick;
    // helpers
    logic signed [12:0]      thrScaled, compVal;
    logic [LOAD_W-1:0]       compLoad;
    logic [VEL_W-1:0]        velMag;
    logic                    velOk, stallHit, evRead;
    logic                    waitStart;                 // halt released this cycle

    // microsecond enable divider; keeps the wait count narrow
    // restarted as the wait begins, so a stray early tick cannot cut the wait short
    always_comb begin
        waitStart   = (state_r == ST_HALT) && (!event_r[EV_STALL_BIT] || !stopEn_r);
        tick        = (tickCnt_r == 7'(TICK_CYCLES - 1));
        tickCnt_nxt = (tick || waitStart) ? 7'h00 : tickCnt_r + 7'h01;
    end

    // signed threshold shifts the reading; higher is less sensitive
    always_comb begin
        thrScaled = {{(13-THR_W-THR_SHIFT){thr_r[THR_W-1]}}, thr_r, 4'h0};
        compVal   = signed'({3'h0, rawLoad}) + thrScaled;
        if (compVal < 13'sh0000) begin
            compLoad = 10'h000;
        end else if (compVal > signed'({3'h0, LOAD_MAX})) begin
            compLoad = LOAD_MAX;
        end else begin
            compLoad = compVal[LOAD_W-1:0];
        end
    end

    // load update per full step, or every fourth step when filtered
    always_comb begin
        load_nxt    = load_r;
        loadUpd_nxt = 1'b0;
        acc_nxt     = acc_r;
        phase_nxt   = phase_r;
        if (fullStepStrobe) begin
            if (filtEn_r) begin
                // average of four keeps precision; stall response slows 4x
                if (phase_r == 2'(FILT_LEN - 1)) begin
                    load_nxt    = 10'((acc_r + {2'h0, compLoad}) >> 2);
                    loadUpd_nxt = 1'b1;
                    acc_nxt     = '0;
                    phase_nxt   = 2'h0;
                end else begin
                    acc_nxt   = acc_r + {2'h0, compLoad};
                    phase_nxt = phase_r + 2'h1;
                end
            end else begin
                load_nxt    = compLoad;
                loadUpd_nxt = 1'b1;
                acc_nxt     = '0;
                phase_nxt   = 2'h0;
            end
        end
    end

    // velocity window for a trusted reading
    always_comb begin
        velMag   = presentVelocity[VEL_W-1] ? VEL_W'(-presentVelocity) : presentVelocity;
        velOk    = (velMag >= vLow_r) && (velMag <= vHigh_r);
        stallHit = loadUpd_r && (load_r == 10'h000) && stopEn_r && velOk
                   && (state_r == ST_RUN);
        evRead   = regRd && (regAddr == OFS_EVENT);
    end

    // stop sequencer: halt on stall, release, then standstill wait
    always_comb begin
        state_nxt   = state_r;
        waitCnt_nxt = waitCnt_r;
        unique case (state_r)
            ST_RUN: begin
                if (stallHit) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                // held until the event is read away or stop disabled
                if (waitStart) begin
                    state_nxt   = ST_WAIT;
                    waitCnt_nxt = '0;
                end
            end
            ST_WAIT: begin
                if (waitCnt_r >= waitTime_r) begin
                    state_nxt = ST_RUN;
                end else if (tick) begin
                    waitCnt_nxt = waitCnt_r + 16'h0001;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // register writes, sticky events and read data
    always_comb begin
        stopEn_nxt   = stopEn_r;
        filtEn_nxt   = filtEn_r;
        thr_nxt      = thr_r;
        vLow_nxt     = vLow_r;
        vHigh_nxt    = vHigh_r;
        waitTime_nxt = waitTime_r;
        mask_nxt     = mask_r;
        rdData_nxt   = '0;
        event_nxt    = event_r;
        if (regWr) begin
            unique case (regAddr)
                OFS_CONFIG: begin
                    stopEn_nxt = regWrData[CFG_STOP_BIT];
                    filtEn_nxt = regWrData[CFG_FILT_BIT];
                    thr_nxt    = regWrData[CFG_THR_LSB +: THR_W];
                end
                OFS_VLOW:  vLow_nxt     = regWrData[VEL_W-1:0];
                OFS_VHIGH: vHigh_nxt    = regWrData[VEL_W-1:0];
                OFS_WAIT:  waitTime_nxt = regWrData[WAIT_W-1:0];
                OFS_MASK:  mask_nxt     = regWrData[EV_W-1:0];
                default: begin
                end
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                OFS_CONFIG: begin
                    rdData_nxt[CFG_STOP_BIT]              = stopEn_r;
                    rdData_nxt[CFG_FILT_BIT]              = filtEn_r;
                    rdData_nxt[CFG_THR_LSB +: THR_W]      = thr_r;
                end
                OFS_VLOW:  rdData_nxt[VEL_W-1:0]  = vLow_r;
                OFS_VHIGH: rdData_nxt[VEL_W-1:0]  = vHigh_r;
                OFS_WAIT:  rdData_nxt[WAIT_W-1:0] = waitTime_r;
                OFS_EVENT: rdData_nxt[EV_W-1:0]   = event_r;
                OFS_MASK:  rdData_nxt[EV_W-1:0]   = mask_r;
                OFS_DRVSTAT: begin
                    rdData_nxt[LOAD_W-1:0]  = load_r;
                    rdData_nxt[DS_STALL_BIT] = (state_r == ST_HALT);
                    rdData_nxt[DS_WAIT_BIT]  = (state_r == ST_WAIT);
                end
                default: begin
                end
            endcase
        end
        // clear on read first, so a same-cycle set survives
        if (evRead) begin
            event_nxt = '0;
        end
        if (stallHit) begin
            event_nxt[EV_STALL_BIT] = 1'b1;
        end
        if (loadUpd_r) begin
            event_nxt[EV_LOAD_BIT] = 1'b1;
        end
    end

    // state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stopEn_r   <= 1'b0;
            filtEn_r   <= 1'b0;
            thr_r      <= '0;
            vLow_r     <= VLOW_RST;
            vHigh_r    <= VHIGH_RST;
            waitTime_r <= WAIT_RST;
            mask_r     <= '0;
            event_r    <= '0;
            rdData_r   <= '0;
            load_r     <= LOAD_MAX;
            loadUpd_r  <= 1'b0;
            acc_r      <= '0;
            phase_r    <= 2'h0;
            state_r    <= ST_RUN;
            waitCnt_r  <= '0;
            tickCnt_r  <= 7'h00;
        end else begin
            stopEn_r   <= stopEn_nxt;
            filtEn_r   <= filtEn_nxt;
            thr_r      <= thr_nxt;
            vLow_r     <= vLow_nxt;
            vHigh_r    <= vHigh_nxt;
            waitTime_r <= waitTime_nxt;
            mask_r     <= mask_nxt;
            event_r    <= event_nxt;
            rdData_r   <= rdData_nxt;
            load_r     <= load_nxt;
            loadUpd_r  <= loadUpd_nxt;
            acc_r      <= acc_nxt;
            phase_r    <= phase_nxt;
            state_r    <= state_nxt;
            waitCnt_r  <= waitCnt_nxt;
            tickCnt_r  <= tickCnt_nxt;
        end
    end

    // outputs: halt covers the stop and the standstill wait
    assign regRdData         = rdData_r;
    assign rampHalt          = (state_r != ST_RUN);
    assign forceVelocityZero = (state_r != ST_RUN);
    assign irq               = |(event_r & mask_r);

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_stall;
        stallHit;
    endsequence
    sequence s_halted;
        (state_r == ST_HALT) && rampHalt && forceVelocityZero;
    endsequence

    property p_update;
        fullStepStrobe && !filtEn_r |=> loadUpd_r && (load_r == $past(compLoad));
    endproperty
    a_update: assert property (p_update) else $error("load not updated on step");

    property p_filter;
        fullStepStrobe && filtEn_r && (phase_r != 2'h3) |=> !loadUpd_r;
    endproperty
    a_filter: assert property (p_filter) else $error("filtered update too early");

    property p_stop;
        s_stall |=> s_halted;
    endproperty
    a_stop: assert property (p_stop) else $error("stall did not halt");

    property p_zero;
        loadUpd_r && (load_r == 10'h000) && stopEn_r && velOk && (state_r == ST_RUN)
            |=> event_r[EV_STALL_BIT] ##0 rampHalt;
    endproperty
    a_zero: assert property (p_zero) else $error("zero load not treated as stall");

    property p_flag;
        regRd && (regAddr == OFS_DRVSTAT)
            |=> regRdData[DS_STALL_BIT] == ($past(state_r) == ST_HALT);
    endproperty
    a_flag: assert property (p_flag) else $error("stall flag wrong");

    property p_clear;
        evRead && !stallHit |=> !event_r[EV_STALL_BIT];
    endproperty
    a_clear: assert property (p_clear) else $error("event not cleared by read");

    property p_release;
        (state_r == ST_HALT) && !stopEn_r |=> (state_r == ST_WAIT) && rampHalt;
    endproperty
    a_release: assert property (p_release) else $error("disable did not release");

    property p_hold;
        (state_r == ST_HALT) && event_r[EV_STALL_BIT] && stopEn_r |=> s_halted;
    endproperty
    a_hold: assert property (p_hold) else $error("halt dropped early");

    property p_window;
        loadUpd_r && !velOk && (state_r == ST_RUN) |=> (state_r == ST_RUN);
    endproperty
    a_window: assert property (p_window) else $error("stall outside window");

    property p_wait;
        (state_r == ST_WAIT) && (waitCnt_r < waitTime_r) |=> (state_r == ST_WAIT);
    endproperty
    a_wait: assert property (p_wait) else $error("restart before wait elapsed");
endmodule // ssds_stall_detect

//--- test/sensorless_stall_detect_stop_tb.sv
// self-checking bench for the stall detect and stop block
`timescale 1ns/1ns
module sensorless_stall_detect_stop_tb;
    import ssds_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWrData = 32'h00000000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdData;
    logic        stepReq = 1'b0;
    logic [9:0]  rawIn = 10'h000;
    logic [23:0] speed = 24'h0003E8;   // well above the reset lower bound of zero, below the 0000FFFF bound of the window test
    logic        fullStepStrobe, rampHalt, forceVelocityZero, irq;
    logic [9:0]  rawLoad;
    logic signed [23:0] presentVelocity;
    logic [31:0] rd;
    logic [9:0]  lastLoad;
    int          sum;
    int          thr;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 32'h68cbd67d;  // fixed so a run repeats
    always #5 ref_clk = ~ref_clk;
    // device under test
    ssds_stall_detect i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .fullStepStrobe(fullStepStrobe), .rawLoad(rawLoad), .presentVelocity(presentVelocity),
        .rampHalt(rampHalt), .forceVelocityZero(forceVelocityZero), .irq(irq));
    // far side: motor and ramp
    ssds_motor_model i_motor (.ref_clk(ref_clk), .reset_n(reset_n), .stepReq(stepReq),
        .rawIn(rawIn), .speed(speed), .velZero(forceVelocityZero),
        .fullStepStrobe(fullStepStrobe), .rawLoad(rawLoad), .presentVelocity(presentVelocity));
    // compare and count; a mismatch prints at once
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // single-cycle write; the strobe drops at the next edge, leaving a gap
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // single-cycle read; data stand only in the following cycle
    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    // config word: stop enable, filter, signed threshold
    function automatic logic [31:0] cfg(input int t, input logic f, input logic s);
        logic [6:0] t7;
        t7 = t[6:0];
        return {17'h00000, t7, 6'h00, f, s};
    endfunction
    // expected load: reading shifted by sixteen counts per threshold step, clamped
    function automatic logic [9:0] expLoad(input logic [9:0] raw, input int t);
        int v;
        v = int'(raw) + t * 16;
        if (v < 0) v = 0;
        if (v > 1023) v = 1023;
        return v[9:0];
    endfunction
    // one full step with a given reading, then let it land
    task automatic step(input logic [9:0] r);
        @(posedge ref_clk);
        stepReq <= 1'b1; rawIn <= r;
        @(posedge ref_clk);
        stepReq <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        // reset values, unmapped index ignored on write and zero on read
        regWrite(4'h9, 32'hFFFFFFFF);
        for (int a = 0; a < 10; a++) begin
            regRead(a[3:0], rd);
            check("reset value", a == 2 ? 32'h00FFFFFF : a == 6 ? 32'h000003FF : 0, rd);
        end
        // load tracks each full step with signed threshold, clamped corners first
        for (int i = 0; i < 8; i++) begin
            thr = i == 0 ? -64 : i == 1 ? 63 : $random(seed) % 64;
            regWrite(OFS_CONFIG, cfg(thr, 1'b0, 1'b0));
            rawIn <= i == 0 ? 10'h010 : i == 1 ? 10'h3F0 : 10'($random(seed));
            @(posedge ref_clk);
            step(rawIn);
            regRead(OFS_DRVSTAT, rd);
            check("load", {22'h000000, expLoad(rawIn, thr)}, rd & 32'h000303FF);
        end
        // filter: an unfiltered step restarts the phase, then four averaged
        regWrite(OFS_CONFIG, cfg(0, 1'b0, 1'b0));
        step(10'h200);
        regWrite(OFS_CONFIG, cfg(0, 1'b1, 1'b0));
        sum = 0;
        for (int i = 0; i < 4; i++) begin
            rawIn <= 10'($random(seed));
            @(posedge ref_clk);
            sum += int'(rawIn);
            step(rawIn);
            regRead(OFS_DRVSTAT, rd);
            lastLoad = i == 3 ? 10'(sum / 4) : 10'h200;
            check("filtered load", {22'h000000, lastLoad}, rd & 32'h000003FF);
        end
        // stall with stop enabled, interrupt unmasked, wait of two microseconds
        regWrite(OFS_CONFIG, cfg(0, 1'b0, 1'b0));
        regWrite(OFS_WAIT, 32'h00000002);
        regWrite(OFS_MASK, 32'h00000001);
        regRead(OFS_EVENT, rd);
        regWrite(OFS_CONFIG, cfg(0, 1'b0, 1'b1)); // enabled at speed
        step(10'h000);
        check("halt", 32'h00000003, {30'h0, rampHalt, forceVelocityZero});
        check("irq", 32'h00000001, {31'h0, irq});
        repeat (30) @(posedge ref_clk);
        check("velocity", 32'h00000000, {8'h00, presentVelocity});
        regRead(OFS_DRVSTAT, rd);
        check("stall flag", 32'h00010000, rd & 32'h00010000);
        regRead(OFS_EVENT, rd);
        check("event", 32'h00000003, rd);
        repeat (150) @(posedge ref_clk);
        check("still waiting", 32'h00000001, {31'h0, rampHalt});
        check("irq cleared", 32'h00000000, {31'h0, irq});
        regRead(OFS_DRVSTAT, rd);
        check("wait flag", 32'h00020000, rd & 32'h00030000);
        repeat (200) @(posedge ref_clk);
        check("restart", 32'h00000000, {31'h0, rampHalt});
        check("velocity back", {8'h00, speed}, {8'h00, presentVelocity});
        // masked stall, released by turning the stop enable off
        regWrite(OFS_MASK, 32'h00000000);
        step(10'h000);
        check("masked irq", 32'h00000000, {31'h0, irq});
        regWrite(OFS_CONFIG, cfg(0, 1'b0, 1'b0));
        repeat (350) @(posedge ref_clk);
        check("release", 32'h00000000, {31'h0, rampHalt});
        regRead(OFS_EVENT, rd);
        check("event kept", 32'h00000001, rd & 32'h00000001);
        // speed below the lower bound: a zero reading does not stop
        regWrite(OFS_VLOW, 32'h0000FFFF);
        regWrite(OFS_CONFIG, cfg(0, 1'b0, 1'b1));
        step(10'h000);
        check("outside window", 32'h00000000, {31'h0, rampHalt});
        regWrite(OFS_VLOW, 32'h00000000);
        give_verdict();
    end
endmodule // sensorless_stall_detect_stop_tb

//--- test/ssds_motor_model.sv
// motor and ramp generator stand-in that feeds the measurement side
`timescale 1ns/1ns
module ssds_motor_model
    import ssds_pkg::*;
(
    // clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            reset_n,
    // bench control
    input  wire logic                            stepReq,
    input  wire logic [ssds_pkg::LOAD_W-1:0]     rawIn,
    input  wire logic [ssds_pkg::VEL_W-1:0]      speed,
    // device side
    input  wire logic                            velZero,
    output logic                                 fullStepStrobe,
    output logic      [ssds_pkg::LOAD_W-1:0]     rawLoad,
    output logic signed [ssds_pkg::VEL_W-1:0]    presentVelocity
);
    // a halted ramp takes no step and its velocity drops to zero at once
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fullStepStrobe  <= 1'b0;
            rawLoad         <= 10'h155;
            presentVelocity <= '0;
        end else begin
            fullStepStrobe  <= stepReq & ~velZero;
            // outside a step the reading is junk that flips every cycle
            rawLoad         <= stepReq ? rawIn : ~rawLoad;
            presentVelocity <= velZero ? '0 : speed;
        end
    end
endmodule // ssds_motor_model
